// ==== rtl/vmw_pkg.sv ====
// Purpose: constants for the mezzanine carrier window decode and irq routing
// Assumes: switches are static while the board is in use
// Notes:   route fields packed {line_one, line_zero}, three bits each
// Contract
// - size code zero disables all A24 decode
// - codes 1-8 split window, halves to A,B
// - codes 9-B whole to A, C-E to B
// - base bits from high/low switches, low bits zero
// - window aligned to its size, compare upper bits
// - hit forwards access with slot-relative offset
// - map codes 8-F hide registers, grow id space
// - level fields 6:4 and 2:0, zero disables
// - lowest field bit is level lsb
// - reset routing from map switch, mirrored above 8
// - slot B area sits 0x100 above slot A
package vmw_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // window size codes
  localparam logic [3:0] SIZE_OFF       = 4'h0;
  localparam logic [3:0] SIZE_SPLIT_MAX = 4'h8;
  localparam logic [3:0] SIZE_A_FIRST   = 4'h9;
  localparam logic [3:0] SIZE_B_FIRST   = 4'hc;
  localparam logic [3:0] SIZE_RSVD      = 4'hf;
  localparam logic [4:0] SPLIT_LOG2_MIN = 5'h10;  // 64 KB at code 1
  localparam logic [4:0] WHOLE_LOG2_MIN = 5'h15;  // 2 MB at first whole code
  localparam int         BASE_LSB       = 16;
  ////////////////////////////////////////////////////////////////////////////
  // A16 area layout, offsets within the 512-byte area
  localparam logic [8:0] SLOT_B_OFF     = 9'h100;
  localparam logic [7:0] ID_BASE        = 8'h80;
  localparam logic [7:0] REG_BASE       = 8'hc0;
  localparam logic [8:0] SLOT_A_IRQ_OFF = 9'h0c1;
  localparam logic [8:0] SLOT_B_IRQ_OFF = 9'h1c1;
  localparam logic [7:0] IRQ_REG_OFF    = 8'hc1;
  localparam int         LINE_ONE_LSB   = 4;
  localparam int         LINE_ZERO_LSB  = 0;
  localparam logic [2:0] LEVEL_OFF      = 3'h0;
  ////////////////////////////////////////////////////////////////////////////
  // map switch: bit 3 hides registers, low bits pick a set
  localparam int         MAP_HIDE_BIT   = 3;
  localparam logic [2:0] MAP_LAST_SET   = 3'h4;
  // packed {a0, a1, b0, b1} reset levels per set
  localparam logic [11:0] MAP_SET_0     = 12'h000;
  localparam logic [11:0] MAP_SET_1     = 12'h29c;
  localparam logic [11:0] MAP_SET_2     = 12'h951;
  localparam logic [11:0] MAP_SET_3     = 12'hd19;
  localparam logic [11:0] MAP_SET_4     = 12'h252;
endpackage

// ==== rtl/vmw_line_route.sv ====
// Purpose: steer one slot's two request lines onto vme levels
// Assumes: lines are active high and already synchronous
// Notes:   level zero routes nowhere
`timescale 1ns/1ps
module vmw_line_route (
  input  wire logic       line_zero,
  input  wire logic       line_one,
  input  wire logic [2:0] level_zero,
  input  wire logic [2:0] level_one,
  output logic      [7:1] level_req
);
  // one-hot per line, index is the level itself so bit 0 of the field is its lsb
  always_comb begin
    level_req = 7'h00;
    for (int lv = 1; lv < 8; lv++) begin
      if ((line_zero && level_zero == 3'(lv)) || (line_one && level_one == 3'(lv))) begin
        level_req[lv] = 1'b1;
      end
    end
  end
endmodule

// ==== rtl/vmw_bridge.sv ====
// Purpose: A24 window decode and A16 irq routing registers for two slots
// Assumes: cycles arrive as one-cycle strobes already decoded to this board
// Notes:   answers come one clock after the strobe, all outputs registered
`timescale 1ns/1ps
module vmw_bridge (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic [3:0]  irq_map_select_switch,
  input  wire logic [3:0]  window_size_switch,
  input  wire logic [3:0]  window_base_high_switch,
  input  wire logic [3:0]  window_base_low_switch,
  input  wire logic        a24_cycle,
  input  wire logic [23:0] a24_addr,
  input  wire logic        a16_cycle,
  input  wire logic        a16_write,
  input  wire logic [8:0]  a16_addr,
  input  wire logic [7:0]  a16_wdata,
  input  wire logic        slot_a_line_zero,
  input  wire logic        slot_a_line_one,
  input  wire logic        slot_b_line_zero,
  input  wire logic        slot_b_line_one,
  output logic             mem_sel_a,
  output logic             mem_sel_b,
  output logic [22:0]      mem_offset,
  output logic             a16_ack,
  output logic [7:0]       a16_rdata,
  output logic [1:0]       io_sel,
  output logic [1:0]       id_sel,
  output logic [7:1]       vme_irq_req
);
  ////////////////////////////////////////////////////////////////////////////
  // window geometry from the size switch
  logic        win_en;
  logic        win_split;
  logic        win_only_b;
  logic [4:0]  win_log2;
  logic [23:0] win_mask;
  logic [23:0] half_mask;
  logic [23:0] win_base;
  logic        win_hit;
  logic        win_upper;

  always_comb begin
    win_en     = 1'b1;
    win_split  = 1'b0;
    win_only_b = 1'b0;
    win_log2   = vmw_pkg::SPLIT_LOG2_MIN;
    if (window_size_switch == vmw_pkg::SIZE_OFF ||
        window_size_switch == vmw_pkg::SIZE_RSVD) begin
      win_en = 1'b0;
    end else if (window_size_switch <= vmw_pkg::SIZE_SPLIT_MAX) begin
      win_split = 1'b1;
      win_log2  = 5'(vmw_pkg::SPLIT_LOG2_MIN + {1'b0, window_size_switch} - 5'h01);
    end else if (window_size_switch >= vmw_pkg::SIZE_B_FIRST) begin
      win_only_b = 1'b1;
      win_log2   = 5'(vmw_pkg::WHOLE_LOG2_MIN + {1'b0, window_size_switch}
                      - {1'b0, vmw_pkg::SIZE_B_FIRST});
    end else begin
      win_log2 = 5'(vmw_pkg::WHOLE_LOG2_MIN + {1'b0, window_size_switch}
                    - {1'b0, vmw_pkg::SIZE_A_FIRST});
    end
  end

  // aligned compare: only bits above the window size take part
  assign win_base  = {window_base_high_switch, window_base_low_switch,
                      16'h0000};
  assign win_mask  = 24'((25'h000_0001 << win_log2) - 25'h000_0001);
  assign half_mask = win_mask >> 1;
  assign win_hit   = win_en && ((a24_addr ^ win_base) & ~win_mask) == 24'h00_0000;
  assign win_upper = |(a24_addr & win_mask & ~half_mask);

  ////////////////////////////////////////////////////////////////////////////
  // A24 answer registers
  logic        sel_a_d, sel_a_q;
  logic        sel_b_d, sel_b_q;
  logic [22:0] offset_d, offset_q;

  // offset is relative to the start of the slot's part of the window
  always_comb begin
    sel_a_d  = 1'b0;
    sel_b_d  = 1'b0;
    offset_d = 23'h00_0000;
    if (a24_cycle && win_hit) begin
      if (win_split) begin
        sel_b_d  = win_upper;
        sel_a_d  = !win_upper;
        offset_d = 23'(a24_addr & half_mask);
      end else begin
        sel_b_d  = win_only_b;
        sel_a_d  = !win_only_b;
        offset_d = 23'(a24_addr & win_mask);
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sel_a_q  <= 1'b0;
      sel_b_q  <= 1'b0;
      offset_q <= 23'h00_0000;
    end else begin
      sel_a_q  <= sel_a_d;
      sel_b_q  <= sel_b_d;
      offset_q <= offset_d;
    end
  end

  assign mem_sel_a  = sel_a_q;
  assign mem_sel_b  = sel_b_q;
  assign mem_offset = offset_q;

  ////////////////////////////////////////////////////////////////////////////
  // A16 decode and routing registers
  logic             regs_on;
  logic             slot;
  logic [7:0]       lo_addr;
  logic             map_valid;
  logic [11:0]      map_set;
  logic             loaded_d, loaded_q;
  logic [1:0][5:0]  route_d, route_q;
  logic             ack_d, ack_q;
  logic [7:0]       rdata_d, rdata_q;
  logic [1:0]       io_d, io_q;
  logic [1:0]       id_d, id_q;

  assign regs_on   = !irq_map_select_switch[vmw_pkg::MAP_HIDE_BIT];
  assign slot      = a16_addr[8];
  assign lo_addr   = a16_addr[7:0];
  assign map_valid = irq_map_select_switch[2:0] <= vmw_pkg::MAP_LAST_SET;

  // set picked by the low bits only, so 8-F mirror 0-7
  always_comb begin
    unique case (irq_map_select_switch[2:0])
      3'h1:    map_set = vmw_pkg::MAP_SET_1;
      3'h2:    map_set = vmw_pkg::MAP_SET_2;
      3'h3:    map_set = vmw_pkg::MAP_SET_3;
      3'h4:    map_set = vmw_pkg::MAP_SET_4;
      default: map_set = vmw_pkg::MAP_SET_0;
    endcase
  end

  // switch is a strap: caught on the first edge after reset, never under it
  always_comb begin
    loaded_d = 1'b1;
    route_d  = route_q;
    ack_d    = a16_cycle;
    rdata_d  = 8'h00;
    io_d     = 2'b00;
    id_d     = 2'b00;
    if (!loaded_q) begin
      route_d[0] = {map_set[8:6], map_set[11:9]};
      route_d[1] = {map_set[2:0], map_set[5:3]};
    end else if (a16_cycle) begin
      if (lo_addr < vmw_pkg::ID_BASE) begin
        io_d[slot] = 1'b1;
      end else if (lo_addr < vmw_pkg::REG_BASE || !regs_on) begin
        id_d[slot] = 1'b1;
      end else if (lo_addr == vmw_pkg::IRQ_REG_OFF) begin
        if (a16_write) begin
          route_d[slot] = {a16_wdata[6:4], a16_wdata[2:0]};
        end else begin
          rdata_d = {1'b0, route_q[slot][5:3], 1'b0, route_q[slot][2:0]};
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      loaded_q <= 1'b0;
      route_q  <= '0;
      ack_q    <= 1'b0;
      rdata_q  <= 8'h00;
      io_q     <= 2'b00;
      id_q     <= 2'b00;
    end else begin
      loaded_q <= loaded_d;
      route_q  <= route_d;
      ack_q    <= ack_d;
      rdata_q  <= rdata_d;
      io_q     <= io_d;
      id_q     <= id_d;
    end
  end

  assign a16_ack   = ack_q;
  assign a16_rdata = rdata_q;
  assign io_sel    = io_q;
  assign id_sel    = id_q;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt routing onto the backplane levels
  logic [7:1] req_a;
  logic [7:1] req_b;
  logic [7:1] irq_d, irq_q;

  vmw_line_route u_route_a (
    .line_zero  (slot_a_line_zero),
    .line_one   (slot_a_line_one),
    .level_zero (route_q[0][2:0]),
    .level_one  (route_q[0][5:3]),
    .level_req  (req_a)
  );

  vmw_line_route u_route_b (
    .line_zero  (slot_b_line_zero),
    .line_one   (slot_b_line_one),
    .level_zero (route_q[1][2:0]),
    .level_one  (route_q[1][5:3]),
    .level_req  (req_b)
  );

  // reserved map positions keep every level quiet
  always_comb begin
    irq_d = (map_valid && loaded_q) ? (req_a | req_b) : 7'h00;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irq_q <= 7'h00;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign vme_irq_req = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence s_reg_write(logic [8:0] off);
    a16_cycle && a16_write && a16_addr == off && regs_on && loaded_q;
  endsequence

  a_size_off_quiet: assert property (
    a24_cycle && window_size_switch == vmw_pkg::SIZE_OFF |=> !mem_sel_a && !mem_sel_b)
    else $error("window decoded while size switch is zero");

  a_split_upper_b: assert property (
    a24_cycle && window_size_switch == 4'h1 && a24_addr[23:16] == win_base[23:16]
    && a24_addr[15] |=> mem_sel_b && !mem_sel_a && mem_offset == 23'($past(a24_addr[14:0])))
    else $error("upper half of 64 KB window not sent to slot B");

  a_whole_slot_a: assert property (
    a24_cycle && window_size_switch == 4'h9 && a24_addr[23:21] == win_base[23:21]
    |=> mem_sel_a && !mem_sel_b && mem_offset == 23'($past(a24_addr[20:0])))
    else $error("2 MB whole window not sent to slot A");

  a_base_miss: assert property (
    a24_cycle && window_size_switch == 4'h2 && a24_addr[23:17] != win_base[23:17]
    |=> !mem_sel_a && !mem_sel_b)
    else $error("access outside aligned window answered");

  a_rsvd_size: assert property (
    a24_cycle && window_size_switch == vmw_pkg::SIZE_RSVD |=> !mem_sel_a && !mem_sel_b)
    else $error("reserved size code decoded");

  a_hidden_regs_id: assert property (
    a16_cycle && !regs_on && loaded_q && lo_addr >= vmw_pkg::REG_BASE
    |=> a16_ack && id_sel[$past(slot)] && a16_rdata == 8'h00)
    else $error("register range not handed to id space");

  a_write_slot_b: assert property (
    s_reg_write(vmw_pkg::SLOT_B_IRQ_OFF) |=> route_q[1] ==
      {$past(a16_wdata[6:4]), $past(a16_wdata[2:0])} && $stable(route_q[0]))
    else $error("slot B route write misplaced");

  a_read_gaps_zero: assert property (
    a16_cycle && !a16_write && regs_on && loaded_q && lo_addr == vmw_pkg::IRQ_REG_OFF
    |=> a16_rdata[7] == 1'b0 && a16_rdata[3] == 1'b0 && a16_ack)
    else $error("unassigned route bits not zero");

  a_reset_set_two: assert property (
    $rose(loaded_q) && irq_map_select_switch[2:0] == 3'h2
    |-> route_q[0] == 6'b101_100 && route_q[1] == 6'b001_010)
    else $error("map set 2 reset levels wrong");

  a_level_routed: assert property (
    loaded_q && map_valid && slot_a_line_zero && route_q[0][2:0] == 3'h5
    |=> vme_irq_req[5])
    else $error("line zero not raised on its level");

  a_level_off: assert property (
    loaded_q && route_q[0] == 6'h00 && route_q[1] == 6'h00 ##1 route_q == '0 |-> vme_irq_req == 7'h00)
    else $error("disabled fields raised a level");

  a_rsvd_map_quiet: assert property (
    !map_valid ##1 !map_valid |-> vme_irq_req == 7'h00)
    else $error("reserved map code routed a request");
endmodule

// ==== bench/vmw_mezz_model.sv ====
// Purpose: stand-in for the two mezzanine modules behind the carrier
// Assumes: selects from the carrier are one-cycle pulses
// Notes:   request lines change just after the clock edge
`timescale 1ns/1ps
module vmw_mezz_model (
  input  wire logic       mclk,
  input  wire logic [3:0] want,
  input  wire logic       mem_sel_a,
  input  wire logic       mem_sel_b,
  output logic      [3:0] lines,
  output int              n_sel_a,
  output int              n_sel_b
);
  ////////////////////////////////////////////////////////////////////////
  // quiet lines at start so the carrier sees no stray request
  initial begin
    lines = 4'h0;
    n_sel_a = 0;
    n_sel_b = 0;
  end
  // lines follow the command one edge late; count every memory select
  always @(posedge mclk) begin
    lines <= #2 want;
    if (mem_sel_a === 1'b1) n_sel_a <= n_sel_a + 1;
    if (mem_sel_b === 1'b1) n_sel_b <= n_sel_b + 1;
  end
endmodule

// ==== bench/vme_mezzanine_window_irq_route_tb_top.sv ====
// Purpose: self-checking bench for window decode and irq routing
// Assumes: switches change only while reset is held
// Notes:   expectations come from integer models of the decode and routing
`timescale 1ns/1ps
module vme_mezzanine_window_irq_route_tb_top;
  logic        mclk = 0, reset_n = 0, a24_cycle = 0, a16_cycle = 0, a16_write = 0;
  logic [3:0]  map_sw = 0, size_sw = 0, hi_sw = 0, lo_sw = 0, want = 0, lines;
  logic [23:0] a24_addr = 0;
  logic [8:0]  a16_addr = 0;
  logic [7:0]  a16_wdata = 0, a16_rdata;
  logic        mem_sel_a, mem_sel_b, a16_ack;
  logic [22:0] mem_offset;
  logic [1:0]  io_sel, id_sel;
  logic [7:1]  vme_irq_req;
  logic [2:0]  lvl [4];
  logic [15:0] sets [8] = '{16'h0000, 16'h1234, 16'h4521, 16'h6431, 16'h1122, 16'h0000,
                            16'h0000, 16'h0000};
  logic [31:0] seed = 32'h38a3_ee8a, r;
  int          n_mismatch = 0, total_checks = 0, cycles = 0, exp_a = 0, exp_b = 0;
  int          seen_a, seen_b, w, base, ad;
  always #25 mclk = ~mclk;
  vmw_bridge dut (.mclk, .reset_n, .irq_map_select_switch(map_sw), .window_size_switch(size_sw),
    .window_base_high_switch(hi_sw), .window_base_low_switch(lo_sw), .a24_cycle, .a24_addr,
    .a16_cycle, .a16_write, .a16_addr, .a16_wdata, .slot_a_line_zero(lines[0]),
    .slot_a_line_one(lines[1]), .slot_b_line_zero(lines[2]), .slot_b_line_one(lines[3]),
    .mem_sel_a, .mem_sel_b, .mem_offset, .a16_ack, .a16_rdata, .io_sel, .id_sel, .vme_irq_req);
  vmw_mezz_model mezz (.mclk, .want, .mem_sel_a, .mem_sel_b, .lines, .n_sel_a(seen_a),
    .n_sel_b(seen_b));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // window log2 per size code; off codes get 16 only to shape addresses
  function automatic int wlog(int c);
    return (c == 0 || c == 15) ? 16 : c <= 8 ? 15 + c : c <= 11 ? 12 + c : 9 + c;
  endfunction
  // {sel_a, sel_b, offset} expected for one address
  function automatic logic [24:0] exp_a24(int c, int b, int a);
    logic [24:0] e;
    int          k;
    e = 0;
    k = wlog(c);
    if (c == 0 || c == 15 || (a >> k) != (b >> k)) return e;
    if (c <= 8) begin
      e[24] = !a[k-1];
      e[23] = a[k-1];
      e[22:0] = 23'(a & ((1 << (k - 1)) - 1));
    end else begin
      e[24] = c < 12;
      e[23] = c >= 12;
      e[22:0] = 23'(a & ((1 << k) - 1));
    end
    return e;
  endfunction
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // switches only move under reset; levels reload from the chosen set
  task automatic do_reset(logic [15:0] sw);
    @(posedge mclk) #2;  // last select pulse must reach the model before reset clears it
    {map_sw, size_sw, hi_sw, lo_sw} = sw;
    reset_n = 0;
    repeat (4) @(posedge mclk);
    #2 reset_n = 1;
    for (int i = 0; i < 4; i++) lvl[i] = sets[map_sw[2:0]][12-4*i +: 3];
    repeat (2) @(posedge mclk);
    #2;
  endtask
  task automatic a24(logic [23:0] a);
    logic [24:0] e;
    e = exp_a24(size_sw, base, a);
    @(posedge mclk) #2 a24_cycle = 1;
    a24_addr = a;
    @(posedge mclk) #2 a24_cycle = 0;
    chk("mem_sel_a", mem_sel_a, e[24]);
    chk("mem_sel_b", mem_sel_b, e[23]);
    chk("mem_offset", mem_offset, e[22:0]);
    exp_a += e[24];
    exp_b += e[23];
  endtask
  task automatic a16(logic wr, logic [8:0] a, logic [7:0] wd);
    logic [7:0] off;
    logic [1:0] s;
    off = a[7:0];
    s = a[8] ? 2'b10 : 2'b01;
    @(posedge mclk) #2 a16_cycle = 1;
    a16_write = wr;
    a16_addr = a;
    a16_wdata = wd;
    @(posedge mclk) #2 a16_cycle = 0;
    chk("a16_ack", a16_ack, 1);
    chk("io_sel", io_sel, off < 8'h80 ? s : 0);
    chk("id_sel", id_sel, (off >= 8'h80 && (off < 8'hc0 || map_sw[3])) ? s : 0);
    if (!wr) chk("a16_rdata", a16_rdata, (off == 8'hc1 && !map_sw[3]) ?
      {1'b0, lvl[2*a[8]+1], 1'b0, lvl[2*a[8]]} : 0);
    if (wr && off == 8'hc1 && !map_sw[3]) begin
      lvl[2*a[8]] = wd[2:0];
      lvl[2*a[8]+1] = wd[6:4];
    end
  endtask
  // lines pass through the model, so allow its edge plus the registered one
  task automatic irq(logic [3:0] ln);
    logic [7:0] e;
    e = 0;
    for (int i = 0; i < 4; i++) if (ln[i] && lvl[i] != 0) e[lvl[i]] = 1;
    if (map_sw[2:0] > 3'h4) e = 0;  // reserved map codes route nothing, written or not
    want = ln;
    repeat (3) @(posedge mclk);
    #2 chk("vme_irq_req", vme_irq_req, e[7:1]);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // hang guard, far above the roughly 830 cycles the run needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles > 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    // every size code with window edges, insides and stray addresses
    for (int c = 0; c < 16; c++) begin
      r = rnd();
      do_reset({4'h2, 4'(c), r[7:0]});
      w = wlog(c);
      base = int'({hi_sw, lo_sw, 16'h0000});
      for (int k = 0; k < 6; k++) begin
        r = rnd();
        if (k == 0) r = 0;
        if (k == 1) r = '1;
        ad = (k < 4) ? (((base >> w) << w) | (r & ((1 << w) - 1))) : r;
        a24(ad[23:0]);
      end
    end
    repeat (2) @(posedge mclk);
    chk("slot_a_selects", seen_a, exp_a);
    chk("slot_b_selects", seen_b, exp_b);
    $display("test a24 decode done");
    // every map code: reset sets, writes, hiding, routing
    for (int m = 0; m < 16; m++) begin
      r = rnd();
      do_reset({4'(m), r[11:0]});
      a16(0, 9'h0c1, 0);
      a16(0, 9'h1c1, 0);
      irq(r[19:16]);
      if (m[2:0] <= 3'h4) begin
        a16(1, 9'h0c1, 8'hd5);
        irq(4'h1);
        a16(1, 9'h0c1, r[23:16]);
        a16(1, 9'h1c1, r[31:24]);
        a16(0, 9'h0c1, 0);
        a16(0, 9'h1c1, 0);
      end else begin
        a16(1, {m[0], 8'hc1}, 8'h77);
      end
      irq(4'hf);
      irq(r[27:24]);
      a16(0, r[8:0], 0);
      a16(0, {r[9], 8'hc3}, 0);
    end
    $display("test a16 registers and routing done");
    give_verdict();
  end
endmodule
